// ---- pin_mux.v ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// per-pin ownership and drive resolution
// ----------------------------------------
module pin_mux (
    input  wire [7:0] direction,
    input  wire [7:0] latch,
    input  wire       spi_en,
    input  wire       master,
    input  wire       ss_out_en,
    input  wire       sci_rx_en,
    input  wire       sci_tx_en,
    input  wire       spi_sck_out,
    input  wire       spi_mosi_out,
    input  wire       spi_miso_out,
    input  wire       sci_txd,
    output reg  [7:0] pin_oe,
    output reg  [7:0] pin_out,
    output reg  [7:0] serial_owned
);
    // ownership picks the data source; direction picks drive except where an enabled serial function forces the pin in or out
    always @* begin
        pin_oe       = direction;
        pin_out      = latch;
        serial_owned = 8'h00;
        if (sci_rx_en) begin
            pin_oe[0] = 1'b0;
        end
        if (sci_tx_en) begin
            pin_oe[1]       = 1'b1;
            pin_out[1]      = sci_txd;
            serial_owned[1] = 1'b1;
        end
        // pins 2 and 3 keep plain gpio behaviour
        if (spi_en) begin
            if (master) begin
                pin_oe[4]  = 1'b0;
                pin_oe[5]  = direction[5];
                pin_out[5] = spi_mosi_out;
                pin_oe[6]  = direction[6];
                pin_out[6] = spi_sck_out;
                serial_owned[6:5] = direction[6:5];
                // direction seven: fault input or ss/gp output
                pin_oe[7] = direction[7];
                if (ss_out_en && direction[7]) begin
                    pin_out[7]      = 1'b0;
                    serial_owned[7] = 1'b1;
                end
            end else begin
                pin_oe[4]       = direction[4];
                pin_out[4]      = spi_miso_out;
                serial_owned[4] = direction[4];
                pin_oe[5]       = 1'b0;
                pin_oe[6]       = 1'b0;
                pin_oe[7]       = 1'b0;
            end
        end
    end
endmodule // pin_mux
`default_nettype wire

// ---- pin_sync.v ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// three-stage pin synchroniser
// ----------------------------------------
module pin_sync #(
    parameter W = 8
) (
    input  wire         mclk,
    input  wire         rst_n,
    input  wire [W-1:0] raw,
    output reg  [W-1:0] level
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;
    // level changes only when stages two and three agree
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1    <= {W{1'b0}};
            s2    <= {W{1'b0}};
            s3    <= {W{1'b0}};
            level <= {W{1'b0}};
        end else begin
            s1    <= raw;
            s2    <= s1;
            s3    <= s2;
            level <= (s2 & s3) | (level & (s2 | s3));
        end
    end
endmodule // pin_sync
`default_nettype wire

// ---- pin_world.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// circuitry outside the pins
// ----------------------------------------
module pin_world (
    input  wire logic       mclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55;
    // an undriven, unpulled pin wanders so no stale level can pass
    always_ff @(posedge mclk) float_pat <= ~float_pat;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & pin_pullup) | (~pin_oe & ~ext_en & ~pin_pullup & float_pat);
endmodule // pin_world
`default_nettype wire

// ---- port_chk_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_s_consts.vh"
// ----------------------------------------
// port checker
// ----------------------------------------
module port_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        spi_enable,
    input wire logic        spi_master,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  pin_pullup,
    input wire logic [7:0]  pin_reduced_drive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [11:0] rd_addr;
    // the answer does not carry its address, so keep it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) rd_addr <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
    end
    property p_reset_state;
        $rose(rst_n) |-> pin_oe == 8'h00 && pin_pullup == 8'hFF && pin_reduced_drive == 8'h00;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("pins not idle after reset");
    property p_pullup_off;
        (pin_oe & pin_pullup) == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on driven pin");
    property p_reduced_groups;
        pin_reduced_drive[7:4] == {4{pin_reduced_drive[7]}} &&
        pin_reduced_drive[3:2] == {2{pin_reduced_drive[3]}} &&
        pin_reduced_drive[1] == pin_reduced_drive[0];
    endproperty
    a_reduced_groups: assert property (p_reduced_groups) else $error("drive group split");
    property p_slave_in;
        spi_enable && !spi_master |-> pin_oe[7:5] == 3'b000;
    endproperty
    a_slave_in: assert property (p_slave_in) else $error("slave input pin driven");
    property p_master_in;
        spi_enable && spi_master |-> !pin_oe[4];
    endproperty
    a_master_in: assert property (p_master_in) else $error("master input pin driven");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_unused_zero;
        s_axi_rvalid && rd_addr == `ADDR_PULLUP_DRIVE |-> s_axi_rdata[7] == 1'b0 && s_axi_rdata[3] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit reads one");
    c_slave: cover property (spi_enable && !spi_master);
    c_select: cover property (spi_enable && spi_master && pin_oe[7]);
    c_pud_read: cover property (s_axi_rvalid && rd_addr == `ADDR_PULLUP_DRIVE);
endmodule // port_chk
bind serial_shared_port_pins port_chk i_chk (
    .mclk(mclk), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .spi_enable(spi_enable), .spi_master(spi_master),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_reduced_drive(pin_reduced_drive)
);
`default_nettype wire

// ---- port_s_consts.vh ----
`ifndef PORT_S_CONSTS_VH
`define PORT_S_CONSTS_VH
// register indices; each register owns one 32-bit word
`define IDX_PIN_DATA         10'h0D6
`define IDX_PIN_DIRECTION    10'h0D7
`define IDX_PULLUP_DRIVE     10'h0DB
`define IDX_SERIAL_CTRL      10'h0E0
`define IDX_SERIAL_STATUS    10'h0E4
// byte address is four times the index
`define ADDR_PIN_DATA        {`IDX_PIN_DATA, 2'b00}
`define ADDR_PIN_DIRECTION   {`IDX_PIN_DIRECTION, 2'b00}
`define ADDR_PULLUP_DRIVE    {`IDX_PULLUP_DRIVE, 2'b00}
`define ADDR_SERIAL_CTRL     {`IDX_SERIAL_CTRL, 2'b00}
`define ADDR_SERIAL_STATUS   {`IDX_SERIAL_STATUS, 2'b00}
// reset values
`define RST_PIN_DATA         8'h00
`define RST_PIN_DIRECTION    8'h00
`define RST_PULLUP_DRIVE     8'h07
`define RST_SERIAL_CTRL      8'h00
// pullup/drive fields
`define PUD_WRITE_MASK       8'h77
`define PUD_PULLUP_LO        0
`define PUD_PULLUP_MID       1
`define PUD_PULLUP_UP        2
`define PUD_RDRV_LO          4
`define PUD_RDRV_MID         5
`define PUD_RDRV_UP          6
// serial control fields
`define SC_SPI_ENABLE        0
`define SC_MASTER            1
`define SC_SS_OUT_EN         2
`define SC_SCI_RX_EN         3
`define SC_SCI_TX_EN         4
`define SC_WRITE_MASK        8'h1F
// axi responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10
`endif

// ---- serial_shared_port_pins.v ----
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "port_s_consts.vh"
module serial_shared_port_pins (
    input  wire        mclk,
    input  wire        rst_n,
    // axi4-lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // serial function side
    input  wire        spi_sck_out,
    input  wire        spi_mosi_out,
    input  wire        spi_miso_out,
    input  wire        sci_txd,
    input  wire        spi_fault_req,
    output wire        spi_enable,
    output wire        spi_master,
    output wire [7:0]  pin_level,
    // pins
    input  wire [7:0]  pin_in,
    output wire [7:0]  pin_out,
    output wire [7:0]  pin_oe,
    output wire [7:0]  pin_pullup,
    output wire [7:0]  pin_reduced_drive
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] latch;
    reg  [7:0] direction;
    reg  [7:0] pullup_drive;
    reg  [7:0] serial_ctrl;
    reg        mode_fault_flag;
    reg  [11:0] aw_addr;
    reg        aw_held;
    reg  [31:0] w_data;
    reg  [3:0] w_strb;
    reg        w_held;
    wire [7:0] serial_owned;
    wire [7:0] mux_oe;
    wire [7:0] mux_out;
    wire [7:0] synced;
    wire       do_write;
    wire       do_read;
    wire       mode_fault_clear;
    reg  [7:0] next_rdata;
    reg        next_rok;

    assign spi_enable = serial_ctrl[`SC_SPI_ENABLE];
    assign spi_master = serial_ctrl[`SC_MASTER];
    assign pin_level  = synced;

    // ----------------------------------------
    // pin path
    // ----------------------------------------
    pin_sync #(.W(8)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .raw   (pin_in),
        .level (synced)
    );

    pin_mux u_mux (
        .direction    (direction),
        .latch        (latch),
        .spi_en       (serial_ctrl[`SC_SPI_ENABLE]),
        .master       (serial_ctrl[`SC_MASTER]),
        .ss_out_en    (serial_ctrl[`SC_SS_OUT_EN]),
        .sci_rx_en    (serial_ctrl[`SC_SCI_RX_EN]),
        .sci_tx_en    (serial_ctrl[`SC_SCI_TX_EN]),
        .spi_sck_out  (spi_sck_out),
        .spi_mosi_out (spi_mosi_out),
        .spi_miso_out (spi_miso_out),
        .sci_txd      (sci_txd),
        .pin_oe       (mux_oe),
        .pin_out      (mux_out),
        .serial_owned (serial_owned)
    );

    assign pin_oe  = mux_oe;
    // latch drives only pins not owned by a serial function
    assign pin_out = mux_out;

    // group enables fanned out; pull-up dropped wherever pin drives
    assign pin_pullup = {{4{pullup_drive[`PUD_PULLUP_UP]}},
                         {2{pullup_drive[`PUD_PULLUP_MID]}},
                         {2{pullup_drive[`PUD_PULLUP_LO]}}} & ~mux_oe;
    assign pin_reduced_drive = {{4{pullup_drive[`PUD_RDRV_UP]}},
                                {2{pullup_drive[`PUD_RDRV_MID]}},
                                {2{pullup_drive[`PUD_RDRV_LO]}}};

    // ----------------------------------------
    // axi write channel capture
    // ----------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;

    // address and data are taken independently, in either order
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 12'h000;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // register updates and write response
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch        <= `RST_PIN_DATA;
            direction    <= `RST_PIN_DIRECTION;
            pullup_drive <= `RST_PULLUP_DRIVE;
            serial_ctrl  <= `RST_SERIAL_CTRL;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (aw_addr & 12'hFFC)
                    (`ADDR_PIN_DATA & 12'hFFC): begin
                        // every register sits alone in its own word
                    end
                    default: begin
                    end
                endcase
                if (aw_addr == `ADDR_PIN_DATA) begin
                    // latch updates whenever byte lane 0 is strobed, even under serial ownership
                    if (w_strb[0]) latch <= w_data[7:0];
                end else if (aw_addr == `ADDR_PIN_DIRECTION) begin
                    if (w_strb[0]) direction <= w_data[7:0];
                end else if (aw_addr == `ADDR_PULLUP_DRIVE) begin
                    if (w_strb[0]) pullup_drive <= w_data[7:0] & `PUD_WRITE_MASK;
                end else if (aw_addr == `ADDR_SERIAL_CTRL) begin
                    if (w_strb[0]) serial_ctrl <= w_data[7:0] & `SC_WRITE_MASK;
                end else if (aw_addr != `ADDR_SERIAL_STATUS) begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // ----------------------------------------
    // mode fault
    // ----------------------------------------
    assign mode_fault_clear = do_write && (aw_addr == `ADDR_SERIAL_STATUS) &&
                              w_strb[0] && w_data[0];
    // fault needs master, spi on and pin seven an input; set beats clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_fault_flag <= 1'b0;
        end else if (direction[7]) begin
            mode_fault_flag <= 1'b0;
        end else if (serial_ctrl[`SC_SPI_ENABLE] && serial_ctrl[`SC_MASTER] &&
                     (spi_fault_req || !synced[7])) begin
            mode_fault_flag <= 1'b1;
        end else if (mode_fault_clear) begin
            mode_fault_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // axi read channel
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign do_read       = s_axi_arvalid && s_axi_arready;

    // readback mixes pin level for inputs and latch for outputs
    always @* begin
        next_rdata = 8'h00;
        next_rok   = 1'b1;
        if (s_axi_araddr == `ADDR_PIN_DATA) begin
            next_rdata = (synced & ~mux_oe) | (latch & mux_oe);
        end else if (s_axi_araddr == `ADDR_PIN_DIRECTION) begin
            next_rdata = direction;
        end else if (s_axi_araddr == `ADDR_PULLUP_DRIVE) begin
            next_rdata = pullup_drive & `PUD_WRITE_MASK;
        end else if (s_axi_araddr == `ADDR_SERIAL_CTRL) begin
            next_rdata = serial_ctrl;
        end else if (s_axi_araddr == `ADDR_SERIAL_STATUS) begin
            next_rdata = {7'h00, mode_fault_flag};
        end else begin
            next_rok = 1'b0;
        end
    end

    // one-cycle read answer, held until rready
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, next_rdata};
            s_axi_rresp  <= next_rok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // serial_shared_port_pins
`default_nettype wire

// ---- test_serial_shared_port_pins.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "port_s_consts.vh"
module test_serial_shared_port_pins;
    logic mclk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic sck = 0, mosi = 0, miso = 0, txd = 0, fault = 0, awready, wready, arready, bvalid, rvalid;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp, last_b;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_rd, lvl, ext_en = 0, ext_val = 0;
    logic        en_o, mst_o;
    integer n_mismatch = 0, n_checks = 0;
    always #25 mclk = ~mclk;
    serial_shared_port_pins i_dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .spi_sck_out(sck), .spi_mosi_out(mosi), .spi_miso_out(miso),
        .sci_txd(txd), .spi_fault_req(fault), .spi_enable(en_o), .spi_master(mst_o),
        .pin_level(lvl),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .pin_reduced_drive(pin_rd));
    pin_world i_world (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task hang;
        begin
            n_mismatch = n_mismatch + 1;
            end_sim;
        end
    endtask
    // ----------------------------------------
    // bus cycles; ready is looked at mid-cycle, where nothing moves
    // ----------------------------------------
    // an extra edge at the end keeps the next call off the released strobes
    task wr(input logic [11:0] a, input logic [7:0] d);
        integer i;
        logic ta, tw, tb, got;
        logic [1:0] r;
        begin
            awaddr <= a;
            wdata <= {24'h000000, d};
            awvalid <= 1;
            wvalid <= 1;
            bready <= 1;
            got = 0;
            for (i = 0; i < 40 && !got; i = i + 1) begin
                @(negedge mclk);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bvalid;
                r = bresp;
                @(posedge mclk);
                if (ta) awvalid <= 0;
                if (tw) wvalid <= 0;
                if (tb) begin
                    bready <= 0;
                    last_b = r;
                    got = 1;
                end
            end
            if (!got) hang;
            @(posedge mclk);
        end
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = `RESP_OKAY);
        integer i;
        logic ta, t, got;
        logic [33:0] r;
        begin
            araddr <= a;
            arvalid <= 1;
            rready <= 1;
            got = 0;
            for (i = 0; i < 40 && !got; i = i + 1) begin
                @(negedge mclk);
                ta = arvalid && arready;
                t = rvalid;
                r = {rresp, rdata};
                @(posedge mclk);
                if (ta) arvalid <= 0;
                if (t) begin
                    rready <= 0;
                    got = 1;
                end
            end
            if (!got) hang;
            chk(r, {er, 24'h000000, e});
            @(posedge mclk);
        end
    endtask
    task settle;
        begin
            repeat (6) @(posedge mclk);
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1;
        settle;
        rd(`ADDR_PIN_DIRECTION, 8'h00);
        rd(`ADDR_PULLUP_DRIVE, 8'h07);
        chk(pin_rd, 8'h00);
        rd(`ADDR_PIN_DATA, 8'hFF);
        $display("test reset done");
        ext_en <= 8'hFF;
        ext_val <= 8'hA5;
        settle;
        rd(`ADDR_PIN_DATA, 8'hA5);
        chk(lvl, 8'hA5);
        wr(`ADDR_PIN_DIRECTION, 8'h0F);
        wr(`ADDR_PIN_DATA, 8'h3C);
        settle;
        rd(`ADDR_PIN_DATA, 8'hAC);
        chk({pin_oe, pin_out[3:0], pin_pullup}, {8'h0F, 4'hC, 8'hF0});
        wr(`ADDR_PULLUP_DRIVE, 8'hFF);
        rd(`ADDR_PULLUP_DRIVE, 8'h77);
        chk(pin_rd, 8'hFF);
        wr(`ADDR_PIN_DIRECTION, 8'h00);
        wr(`ADDR_PULLUP_DRIVE, 8'h52);
        chk({pin_rd, pin_pullup, pin_oe}, {8'hF3, 8'h0C, 8'h00});
        $display("test gpio done");
        txd <= 1;
        wr(`ADDR_PIN_DIRECTION, 8'h01);
        wr(`ADDR_SERIAL_CTRL, 8'h18);
        chk({pin_oe[1:0], pin_out[1]}, 3'b101);
        wr(`ADDR_PIN_DATA, 8'h00);
        chk(pin_out[1], 1'b1);
        txd <= 0;
        @(posedge mclk);
        chk(pin_out[1], 1'b0);
        $display("test sci done");
        miso <= 0;
        wr(`ADDR_PIN_DIRECTION, 8'hFF);
        wr(`ADDR_SERIAL_CTRL, 8'h01);
        wr(`ADDR_PIN_DATA, 8'hFF);
        chk({pin_oe, pin_out[4]}, {8'h1F, 1'b0});
        wr(`ADDR_PIN_DIRECTION, 8'h0F);
        chk(pin_oe, 8'h0F);
        mosi <= 1;
        wr(`ADDR_SERIAL_CTRL, 8'h03);
        chk({en_o, mst_o}, 2'b11);
        wr(`ADDR_PIN_DIRECTION, 8'h60);
        chk({pin_oe, pin_out[6:5]}, {8'h60, 2'b01});
        wr(`ADDR_PIN_DIRECTION, 8'hE0);
        chk({pin_oe[7], pin_out[7]}, 2'b11);
        wr(`ADDR_SERIAL_CTRL, 8'h07);
        chk(pin_out[7], 1'b0);
        $display("test spi done");
        wr(`ADDR_SERIAL_CTRL, 8'h03);
        wr(`ADDR_PIN_DIRECTION, 8'h00);
        fault <= 1;
        @(posedge mclk) fault <= 0;
        rd(`ADDR_SERIAL_STATUS, 8'h01);
        wr(`ADDR_SERIAL_STATUS, 8'h01);
        wr(`ADDR_PIN_DIRECTION, 8'h80);
        fault <= 1;
        @(posedge mclk) fault <= 0;
        rd(`ADDR_SERIAL_STATUS, 8'h00);
        wr(`ADDR_SERIAL_CTRL, 8'h00);
        wr(`ADDR_PIN_DIRECTION, 8'hF0);
        chk({pin_oe, pin_out[7:4]}, {8'hF0, 4'hF});
        rd(12'h0D8, 8'h00, `RESP_SLVERR);
        wr(12'h0D8, 8'h5A);
        chk(last_b, `RESP_SLVERR);
        $display("test fault and unmapped done");
        end_sim;
    end
endmodule // test_serial_shared_port_pins
`default_nettype wire
